// ### hdl/eac_access_ctrl.sv
// EEPROM access controller: Wishbone registers, programming sequencer,
// ready interrupt and event interrupt
// Assumes one synchronous clock and a synchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
`include "eac_params.svh"

// Contract
// RULE1 - Byte index is nine bits, locations 0 to 511.
// RULE2 - Index bits 15 to 9 always read zero.
// RULE3 - Software loads a valid index before any access.
// RULE4 - Small variants: software writes zero into the top index bit.
// RULE5 - Value register supplies programmed byte and holds read byte.
// RULE6 - Control bits 7 and 6 always read zero.
// RULE7 - Mode bits 5 and 4 select the action launched by program enable.
// RULE8 - 00 atomic 3.4 ms, 01 erase 1.8 ms, 10 write 1.8 ms, 11 reserved.
// RULE9 - Mode writes ignored while program enable is set.
// RULE10 - Reset clears mode bits unless programming is busy.
// RULE11 - Control bit 3 enables ready interrupt, gated by global enable.
// RULE12 - Ready interrupt is a level while program enable is clear.
// RULE13 - Program enable starts action, hardware clears it on completion.
// RULE14 - Read strobe copies addressed byte, refused while busy.
// RULE15 - Master enable precedes program enable, self-clears after cycles.
module eac_access_ctrl
    import eac_pkg::*;
#(
    parameter int unsigned ATOMIC_CYC = `EAC_CYC_ATOMIC,
    parameter int unsigned SPLIT_CYC  = `EAC_CYC_SPLIT
) (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [31:0] wb_adr_in,
    input  wire logic [31:0] wb_dat_in,
    input  wire logic [3:0]  wb_sel_in,
    output logic [31:0]      wb_dat_out,
    output logic             wb_ack_out,
    output logic             ready_irq_out,
    output logic             event_irq_out
);
    import eac_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [15:0] index;
        logic [7:0]  value;
        eac_mode_t   mode;
        logic        rie;
        logic        master;
        logic [3:0]  master_cnt;
        logic        prog;
        eac_state_t  state;
        logic [23:0] timer;
        logic [1:0]  status;
        logic [1:0]  mask;
        logic        gie;
        logic        ack;
        logic [31:0] rdata;
    } eac_regs_t;

    eac_regs_t    r_q;
    eac_regs_t    r_d;
    eac_mem_req_t mem_req;
    logic [7:0]   mem_rdata;

    function automatic logic [23:0] eac_prog_cycles(input eac_mode_t m);
        begin
            case (m)
                EAC_MODE_ATOMIC: eac_prog_cycles = ATOMIC_CYC[23:0];
                default:         eac_prog_cycles = SPLIT_CYC[23:0];
            endcase
        end
    endfunction

    function automatic logic eac_hit(input logic [31:0] a,
                                     input logic [31:0] ofs);
        begin
            eac_hit = (a[7:2] == ofs[7:2]);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Byte array

    eac_byte_array eac_byte_array_inst (
        .clk_in    (clk_in),
        .req_in    (mem_req),
        .rdata_out (mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state

    logic bus_req;
    logic wr_req;
    logic rd_req;
    logic [7:0] ctl_view;
    logic [7:0] wbyte;

    always_comb begin
        r_d      = r_q;
        mem_req  = '0;
        bus_req  = wb_cyc_in && wb_stb_in && !r_q.ack;
        wr_req   = bus_req && wb_we_in && wb_sel_in[0];
        rd_req   = bus_req && !wb_we_in;
        wbyte    = wb_dat_in[7:0];
        ctl_view = {2'h0, r_q.mode, r_q.rie, r_q.master,               // [RULE6]
                    r_q.prog, 1'b0};
        r_d.ack  = bus_req;

        if (r_q.master_cnt != 4'h0) begin
            r_d.master_cnt = r_q.master_cnt - 4'h1;
        end else begin
            r_d.master = 1'b0;                                          // [RULE15]
        end

        case (r_q.state)
            EAC_ST_IDLE: begin
            end
            EAC_ST_PROG: begin
                if (r_q.timer <= 24'h1) begin
                    // Commit happens at the end so the byte is never half set
                    mem_req.we    = (r_q.mode != EAC_MODE_RSVD);        // [RULE8]
                    mem_req.addr  = r_q.index[8:0];                     // [RULE1]
                    mem_req.wdata = (r_q.mode == EAC_MODE_ERASE) ?
                                    8'hFF : r_q.value;                  // [RULE5]
                    r_d.prog      = 1'b0;                               // [RULE13]
                    r_d.state     = EAC_ST_IDLE;
                    r_d.timer     = 24'h0;
                    r_d.status[`EAC_ST_PROG_DONE] = 1'b1;
                end else begin
                    r_d.timer = r_q.timer - 24'h1;
                end
            end
            EAC_ST_READ: begin
                r_d.value = mem_rdata;                                  // [RULE5]
                r_d.state = EAC_ST_IDLE;
                r_d.status[`EAC_ST_READ_DONE] = 1'b1;
            end
            default: begin
                r_d.state = EAC_ST_IDLE;
            end
        endcase

        if (rd_req) begin
            case (1'b1)
                eac_hit(wb_adr_in, `EAC_OFS_INDEX):
                    r_d.rdata = {16'h0, 7'h0, r_q.index[8:0]};          // [RULE2]
                eac_hit(wb_adr_in, `EAC_OFS_VALUE):
                    r_d.rdata = {24'h0, r_q.value};
                eac_hit(wb_adr_in, `EAC_OFS_CONTROL):
                    r_d.rdata = {24'h0, ctl_view};
                eac_hit(wb_adr_in, `EAC_OFS_STATUS): begin
                    r_d.rdata  = {30'h0, r_q.status};
                    // Set wins over the read clear
                    r_d.status = r_d.status & ~r_q.status;
                    if (r_q.state == EAC_ST_PROG && r_q.timer <= 24'h1)
                        r_d.status[`EAC_ST_PROG_DONE] = 1'b1;
                    if (r_q.state == EAC_ST_READ)
                        r_d.status[`EAC_ST_READ_DONE] = 1'b1;
                end
                eac_hit(wb_adr_in, `EAC_OFS_MASK):
                    r_d.rdata = {30'h0, r_q.mask};
                eac_hit(wb_adr_in, `EAC_OFS_GIE):
                    r_d.rdata = {31'h0, r_q.gie};
                default:
                    r_d.rdata = 32'h0;
            endcase
        end

        if (wr_req) begin
            case (1'b1)
                eac_hit(wb_adr_in, `EAC_OFS_INDEX): begin
                    r_d.index[7:0] = wbyte;                             // [RULE1]
                    if (wb_sel_in[1])
                        r_d.index[8] = wb_dat_in[8];
                    r_d.index[15:9] = 7'h0;                             // [RULE2]
                end
                eac_hit(wb_adr_in, `EAC_OFS_VALUE):
                    r_d.value = wbyte;
                eac_hit(wb_adr_in, `EAC_OFS_CONTROL): begin
                    r_d.rie = wbyte[`EAC_CTL_RIE];                      // [RULE11]
                    if (!r_q.prog) begin
                        r_d.mode = eac_mode_t'(wbyte[5:4]);             // [RULE9]
                    end
                    if (wbyte[`EAC_CTL_MASTER]) begin
                        r_d.master     = 1'b1;                          // [RULE15]
                        r_d.master_cnt = `EAC_MASTER_CYC;
                    end
                    if (wbyte[`EAC_CTL_PROG] && r_q.master && !r_q.prog
                        && r_q.state == EAC_ST_IDLE) begin
                        r_d.prog   = 1'b1;                              // [RULE13]
                        r_d.master = 1'b0;
                        r_d.state  = EAC_ST_PROG;
                        // Mode bits written with the start bit already count
                        r_d.timer  = eac_prog_cycles(r_d.mode);         // [RULE7]
                    end else if (wbyte[`EAC_CTL_READ] && !r_q.prog
                                 && r_q.state == EAC_ST_IDLE) begin
                        mem_req.re   = 1'b1;                            // [RULE14]
                        mem_req.addr = r_q.index[8:0];
                        r_d.state    = EAC_ST_READ;
                    end
                end
                eac_hit(wb_adr_in, `EAC_OFS_MASK):
                    r_d.mask = wbyte[1:0];
                eac_hit(wb_adr_in, `EAC_OFS_GIE):
                    r_d.gie = wbyte[0];
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            r_q       <= '0;
            r_q.state <= EAC_ST_IDLE;
            // A busy array keeps its mode and data through reset, and its timer goes on counting down
            if (r_q.prog) begin                                         // [RULE10]
                r_q.mode  <= r_q.mode;
                r_q.prog  <= r_d.prog;
                r_q.state <= r_d.state;
                r_q.timer <= r_d.timer;
                r_q.index <= r_q.index;
                r_q.value <= r_q.value;
                // A job that ends inside reset reports completion only if reset releases next cycle,
                // and commits once rather than on every reset cycle
                r_q.status[`EAC_ST_PROG_DONE] <= !r_d.prog;
            end else begin
                r_q.mode <= eac_mode_t'(`EAC_MODE_RST);                 // [RULE10]
            end
        end else begin
            r_q <= r_d;
        end
    end

    assign wb_ack_out    = r_q.ack;
    assign wb_dat_out    = r_q.rdata;
    assign ready_irq_out = r_q.rie && r_q.gie && !r_q.prog;            // [RULE12]
    assign event_irq_out = |(r_q.status & r_q.mask);

    ////////////////////////////////////////////////////////////////////////
    // Checks

    AST_IDX_HIGH_ZERO: assert property (@(posedge clk_in)              // [RULE2]
        disable iff (!rst_n_in) r_q.index[15:9] == 7'h0)
        else $error("index upper bits nonzero");

    AST_MODE_HELD: assert property (@(posedge clk_in)                  // [RULE9]
        disable iff (!rst_n_in) r_q.prog |=> r_q.mode == $past(r_q.mode))
        else $error("mode changed while programming");

    AST_READY_LEVEL: assert property (@(posedge clk_in)                // [RULE12]
        disable iff (!rst_n_in)
        ready_irq_out == (r_q.rie && r_q.gie && !r_q.prog))
        else $error("ready interrupt level wrong");

    AST_PROG_START: assert property (@(posedge clk_in)                 // [RULE13]
        disable iff (!rst_n_in)
        $rose(r_q.prog) |-> r_q.state == EAC_ST_PROG && r_q.timer != 0)
        else $error("programming did not start");

    AST_PROG_END: assert property (@(posedge clk_in)                   // [RULE13]
        disable iff (!rst_n_in)
        $fell(r_q.prog) |-> r_q.status[`EAC_ST_PROG_DONE])
        else $error("completion not flagged");

    AST_READ_BLOCKED: assert property (@(posedge clk_in)               // [RULE14]
        disable iff (!rst_n_in) r_q.prog |-> !mem_req.re)
        else $error("read while busy");

    AST_READ_DATA: assert property (@(posedge clk_in)                  // [RULE5]
        disable iff (!rst_n_in)
        mem_req.re |=> ##1 r_q.value == $past(mem_rdata))
        else $error("read byte not captured");

    AST_MASTER_CLEAR: assert property (@(posedge clk_in)               // [RULE15]
        disable iff (!rst_n_in) $rose(r_q.master) |-> ##[1:6] !r_q.master)
        else $error("master enable stuck");

    AST_ACK_PULSE: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) wb_ack_out |=> !wb_ack_out)
        else $error("ack longer than one cycle");

    AST_ACK_ANSWER: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
        else $error("request not answered");

    // Reset checks look at cycles with reset low, so they carry no disable
    AST_MODE_RESET: assert property (@(posedge clk_in)                 // [RULE10]
        !rst_n_in && !r_q.prog |=> r_q.mode == `EAC_MODE_RST)
        else $error("mode not cleared by reset");

    AST_MODE_KEEP: assert property (@(posedge clk_in)                  // [RULE10]
        !rst_n_in && r_q.prog |=> r_q.mode == $past(r_q.mode))
        else $error("busy mode lost in reset");

    AST_PROG_COUNT: assert property (@(posedge clk_in)                 // [RULE8]
        disable iff (!rst_n_in)
        r_q.prog && r_q.timer > 24'h1 |=>
            r_q.timer == $past(r_q.timer) - 24'h1)
        else $error("programming timer not counting");

    AST_START_MASTER: assert property (@(posedge clk_in)               // [RULE15]
        disable iff (!rst_n_in) $rose(r_q.prog) |-> $past(r_q.master))
        else $error("programming started without master enable");

    AST_READ_FLAG: assert property (@(posedge clk_in)                  // [RULE14]
        disable iff (!rst_n_in)
        r_q.state == EAC_ST_READ |=>
            r_q.status[`EAC_ST_READ_DONE] && r_q.state == EAC_ST_IDLE)
        else $error("read completion not flagged");

    AST_ERASE_FF: assert property (@(posedge clk_in)                   // [RULE8]
        disable iff (!rst_n_in)
        mem_req.we && r_q.mode == EAC_MODE_ERASE |-> mem_req.wdata == 8'hFF)
        else $error("erase stored a data byte");

    AST_WRITE_BYTE: assert property (@(posedge clk_in)                 // [RULE5]
        disable iff (!rst_n_in)
        mem_req.we && r_q.mode != EAC_MODE_ERASE |->
            mem_req.wdata == r_q.value)
        else $error("stored byte differs from value register");

    AST_RSVD_NO_STORE: assert property (@(posedge clk_in)              // [RULE8]
        disable iff (!rst_n_in) r_q.mode == EAC_MODE_RSVD |-> !mem_req.we)
        else $error("reserved mode stored a byte");

    AST_COMMIT_END: assert property (@(posedge clk_in)                 // [RULE13]
        disable iff (!rst_n_in)
        mem_req.we |-> r_q.prog && r_q.timer <= 24'h1)
        else $error("byte committed before the job ended");

    COV_PROG: cover property (@(posedge clk_in) $fell(r_q.prog));
    COV_READ: cover property (@(posedge clk_in) mem_req.re);
    COV_IRQ:  cover property (@(posedge clk_in) $rose(event_irq_out));
    COV_RESET_BUSY: cover property (@(posedge clk_in) !rst_n_in && r_q.prog);

endmodule // eac_access_ctrl

`default_nettype wire

// ### hdl/eac_params.svh
// Register offsets, field positions, reset values and timing counts
// Assumes a 250 MHz system clock and 32-bit classic Wishbone
`ifndef EAC_PARAMS_SVH
`define EAC_PARAMS_SVH

`define EAC_OFS_INDEX      32'h0000_0000
`define EAC_OFS_VALUE      32'h0000_0004
`define EAC_OFS_CONTROL    32'h0000_0008
`define EAC_OFS_STATUS     32'h0000_000C
`define EAC_OFS_MASK       32'h0000_0010
`define EAC_OFS_GIE        32'h0000_0014

`define EAC_CTL_READ       0
`define EAC_CTL_PROG       1
`define EAC_CTL_MASTER     2
`define EAC_CTL_RIE        3
`define EAC_CTL_MODE_LO    4
`define EAC_CTL_MODE_HI    5

`define EAC_ST_PROG_DONE   0
`define EAC_ST_READ_DONE   1

`define EAC_ADDR_W         9
`define EAC_MODE_RST       2'h0
`define EAC_MASTER_CYC     4'h4
`define EAC_CLK_MHZ        250
`define EAC_T_ATOMIC_US    3400
`define EAC_T_SPLIT_US     1800
`define EAC_CYC_ATOMIC     (`EAC_T_ATOMIC_US * `EAC_CLK_MHZ)
`define EAC_CYC_SPLIT      (`EAC_T_SPLIT_US * `EAC_CLK_MHZ)

`endif

// ### hdl/eac_pkg.sv
// Types shared by the access controller and its byte array
// Assumes eac_params.svh for the numbers
package eac_pkg;

    typedef enum logic [1:0] {
        EAC_MODE_ATOMIC = 2'h0,
        EAC_MODE_ERASE  = 2'h1,
        EAC_MODE_WRITE  = 2'h2,
        EAC_MODE_RSVD   = 2'h3
    } eac_mode_t;

    typedef enum logic [2:0] {
        EAC_ST_IDLE = 3'h1,
        EAC_ST_PROG = 3'h2,
        EAC_ST_READ = 3'h4
    } eac_state_t;

    typedef struct packed {
        logic       we;
        logic       re;
        logic [8:0] addr;
        logic [7:0] wdata;
    } eac_mem_req_t;

endpackage

// ### hdl/eac_byte_array.sv
// Nonvolatile byte array model: 512 bytes with registered read data
// Assumes one request per cycle from the access controller
`timescale 1ns/100ps
`default_nettype none

module eac_byte_array
    import eac_pkg::*;
(
    input  wire logic                  clk_in,
    input  wire eac_pkg::eac_mem_req_t req_in,
    output logic [7:0]                 rdata_out
);

    logic [7:0] mem [0:511];
    logic [7:0] rdata_q;

    // Array content survives reset, as nonvolatile storage should
    always_ff @(posedge clk_in) begin
        if (req_in.we) begin
            mem[req_in.addr] <= req_in.wdata;
        end
        if (req_in.re) begin
            rdata_q <= mem[req_in.addr];
        end
    end

    assign rdata_out = rdata_q;

endmodule // eac_byte_array

`default_nettype wire

// ### tb/eac_shadow_array.sv
// Shadow of the byte array: expected contents after each programming mode
// Assumes the bench calls apply once per completed operation
`timescale 1ns/100ps
`default_nettype none

module eac_shadow_array;
    logic [7:0] mem [512];

    task automatic apply(input logic [1:0] m, input logic [8:0] a,
                         input logic [7:0] v);
        case (m)
            2'h0: mem[a] = v;
            2'h1: mem[a] = 8'hFF;
            2'h2: mem[a] = v;
            default: ;                 // reserved stores nothing
        endcase
    endtask

    function automatic logic [7:0] peek(input logic [8:0] a);
        return mem[a];
    endfunction
endmodule // eac_shadow_array

`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the access controller over classic Wishbone
// Assumes short programming counts so the run stays brief
`timescale 1ns/100ps
`default_nettype none
`include "eac_params.svh"

module tb_top;
    import eac_pkg::*;
    localparam int AT = 20;
    localparam int SP = 10;
    logic        clk_in;
    logic        rst_n_in;
    logic        cyc;
    logic        stb;
    logic        we;
    logic        ack;
    logic        rdy_irq;
    logic        ev_irq;
    logic        rie;
    logic [3:0]  sel;
    logic [31:0] adr;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic [31:0] r;
    logic [7:0]  vals [4] = '{8'h5A, 8'h00, 8'h3C, 8'h77};
    int          n_errors = 0;
    int          n_compared = 0;
    int          cyc_cnt = 0;
    int          el;
    int          t;

    eac_access_ctrl #(.ATOMIC_CYC(AT), .SPLIT_CYC(SP)) eac_access_ctrl_inst (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(cyc),
        .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_dat_in(wdat),
        .wb_sel_in(sel), .wb_dat_out(rdat), .wb_ack_out(ack),
        .ready_irq_out(rdy_irq), .event_irq_out(ev_irq));
    eac_shadow_array eac_shadow_array_inst ();

    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    always @(posedge clk_in) cyc_cnt <= cyc_cnt + 1;

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Holds the request until ack is sampled, then releases it
    task automatic xfer(input logic w, input logic [31:0] a,
                        input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_in);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        sel  <= s;
        do begin
            @(posedge clk_in);
            n++;
        end while (ack !== 1'b1 && n < 50);
        chk({31'h0, ack}, 32'h1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 4'h1);
    endtask

    task automatic rd(input logic [31:0] a);
        xfer(1'b0, a, 32'h0, 4'hF);
    endtask

    task automatic ctl(input logic [1:0] m, input logic [2:0] low);
        wr(`EAC_OFS_CONTROL, {26'h0, m, rie, low});
    endtask

    task automatic prog(input logic [1:0] m, input logic [7:0] v);
        wr(`EAC_OFS_VALUE, {24'h0, v});
        ctl(2'h0, 3'h4);
        ctl(m, 3'h2);
        // Job length is counted from the acknowledge of the start write
        el = cyc_cnt;
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            rd(`EAC_OFS_CONTROL);
            n++;
        end while (r[1] !== 1'b0 && n < 100);
        el = cyc_cnt - el;
        chk({31'h0, r[1]}, 32'h0);
    endtask

    task automatic print_verdict();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk_in);
        n_errors++;
        print_verdict();
    end

    initial begin
        {cyc, stb, we, rie, rst_n_in} = 5'h0;
        {sel, adr, wdat} = '0;
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd(`EAC_OFS_CONTROL);
        chk(r, 32'h0);
        xfer(1'b1, `EAC_OFS_INDEX, 32'h0000_FFFF, 4'h3);
        rd(`EAC_OFS_INDEX);
        chk(r, 32'h0000_01FF);
        xfer(1'b1, `EAC_OFS_INDEX, 32'h0000_00A5, 4'h3);
        rd(`EAC_OFS_INDEX);
        chk(r, 32'h0000_00A5);
        xfer(1'b1, `EAC_OFS_INDEX, 32'h0000_01A5, 4'h3);
        wr(32'h0000_0018, 32'h0000_00FF);
        rd(32'h0000_0018);
        chk(r, 32'h0);
        wr(`EAC_OFS_GIE, 32'h1);
        wr(`EAC_OFS_MASK, 32'h1);
        rie = 1'b1;
        for (int i = 0; i < 4; i++) begin
            prog(i[1:0], vals[i]);
            chk({31'h0, rdy_irq}, 32'h0);
            ctl(~i[1:0], 3'h3);
            rd(`EAC_OFS_CONTROL);
            chk(r, {26'h0, i[1:0], 4'hA});
            rd(`EAC_OFS_VALUE);
            chk(r, {24'h0, vals[i]});
            wait_idle();
            t = (i == 0) ? AT : SP;
            chk({31'h0, el >= t - 2 && el <= t + 8}, 32'h1);
            chk({31'h0, ev_irq}, 32'h1);
            chk({31'h0, rdy_irq}, 32'h1);
            rd(`EAC_OFS_STATUS);
            chk(r, 32'h1);
            eac_shadow_array_inst.apply(i[1:0], 9'h1A5, vals[i]);
            wr(`EAC_OFS_VALUE, 32'h0);
            ctl(i[1:0], 3'h1);
            repeat (3) @(posedge clk_in);
            rd(`EAC_OFS_VALUE);
            chk(r, {24'h0, eac_shadow_array_inst.peek(9'h1A5)});
            rd(`EAC_OFS_STATUS);
            chk(r, 32'h2);
            chk({31'h0, ev_irq}, 32'h0);
        end
        wr(`EAC_OFS_GIE, 32'h0);
        chk({31'h0, rdy_irq}, 32'h0);
        rie = 1'b0;
        ctl(2'h0, 3'h2);
        rd(`EAC_OFS_CONTROL);
        chk(r, 32'h0);
        ctl(2'h0, 3'h4);
        repeat (8) @(posedge clk_in);
        ctl(2'h0, 3'h2);
        rd(`EAC_OFS_CONTROL);
        chk(r, 32'h0);
        // Reset while busy must not lose the mode of the running job
        prog(2'h2, 8'h11);
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd(`EAC_OFS_CONTROL);
        chk(r, 32'h0000_0022);
        wait_idle();
        eac_shadow_array_inst.apply(2'h2, 9'h1A5, 8'h11);
        ctl(2'h1, 3'h1);
        repeat (3) @(posedge clk_in);
        rd(`EAC_OFS_VALUE);
        chk(r, {24'h0, eac_shadow_array_inst.peek(9'h1A5)});
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd(`EAC_OFS_CONTROL);
        chk(r, 32'h0);
        print_verdict();
    end
endmodule // tb_top

`default_nettype wire
